// ===== dbr_dev.sv
// device end: decodes commands, tracks banks, refresh counter and skipping
// assumes command pins are synchronous to CLK_SYS_I from the controller end
module dbr_dev (
    input  wire logic                          CLK_SYS_I,
    input  wire logic                          RST_I,
    input  wire logic                          CE_I,
    dbr_if.dev                                 link,
    input  wire logic [dbr_pkg::FGR_W-1:0]     FGR_MODE_I,
    input  wire logic                          TEMP_REFRESH_EN_I,
    input  wire logic                          TEMP_BELOW_45_I,
    output logic [dbr_pkg::NBANK-1:0]          BANK_OPEN_O,
    output logic [dbr_pkg::RCNT_W-1:0]         REF_ROW_O,
    output logic                               REF_BUSY_O,
    output logic                               CMD_ERR_O
);
    typedef struct packed {
        logic [dbr_pkg::RCNT_W-1:0]  rcnt;
        logic [dbr_pkg::RFC_W-1:0]   rfc;
        logic [1:0]                  skip;
        logic [dbr_pkg::NBANK-1:0]   open;
        logic                        err;
        logic                        err_o;
        logic                        busy;
    } dbr_dev_st_t;

    dbr_dev_st_t s_q, s_d;

    logic                              is_act, is_pre, is_prea, is_rd, is_wr, is_ref;
    logic [dbr_pkg::BANK_W-1:0]        bank;
    logic [dbr_pkg::NBANK-1:0]         bank_bad;
    dbr_pkg::dbr_bank_t                bank_st [dbr_pkg::NBANK];
    logic [dbr_pkg::RFC_W-1:0]         rfc_len;

    // ************************************************************
    // command decode
    // ************************************************************
    assign bank    = {link.bg, link.ba};
    assign is_act  = !link.cs_n && !link.act_n;
    assign is_ref  = !link.cs_n && link.act_n && !link.ras_n && !link.cas_n
                     && link.we_n;
    assign is_pre  = !link.cs_n && link.act_n && !link.ras_n && link.cas_n && !link.we_n
                     && !link.addr[dbr_pkg::AUTO_PRECHARGE_FLAG_BIT];
    assign is_prea = !link.cs_n && link.act_n && !link.ras_n && link.cas_n && !link.we_n
                     && link.addr[dbr_pkg::AUTO_PRECHARGE_FLAG_BIT];
    assign is_rd   = !link.cs_n && link.act_n && link.ras_n && !link.cas_n && link.we_n;
    assign is_wr   = !link.cs_n && link.act_n && link.ras_n && !link.cas_n && !link.we_n;

    // refresh cycle length from rate mode, OTF picks by bg0
    always_comb
    begin
        rfc_len = dbr_pkg::RFC_W'(dbr_pkg::TRFC1_CYC);
        unique case (FGR_MODE_I)
            dbr_pkg::FGR_FIX2: rfc_len = dbr_pkg::RFC_W'(dbr_pkg::TRFC2_CYC);
            dbr_pkg::FGR_FIX4: rfc_len = dbr_pkg::RFC_W'(dbr_pkg::TRFC4_CYC);
            dbr_pkg::FGR_OTF2: if (link.bg[0]) rfc_len = dbr_pkg::RFC_W'(dbr_pkg::TRFC2_CYC);
            dbr_pkg::FGR_OTF4: if (link.bg[0]) rfc_len = dbr_pkg::RFC_W'(dbr_pkg::TRFC4_CYC);
            default: rfc_len = dbr_pkg::RFC_W'(dbr_pkg::TRFC1_CYC);
        endcase
    end

    // ************************************************************
    // banks
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < dbr_pkg::NBANK; g++)
        begin : g_bank
            logic hit;
            assign hit = (bank == dbr_pkg::BANK_W'(g));
            dbr_bank u_bank (
                .clk_i   (CLK_SYS_I),
                .rst_i   (RST_I),
                .en_i    (CE_I),
                .act_i   (is_act && hit && s_q.rfc == '0),
                .pre_i   ((is_pre && hit) || is_prea),
                .rd_i    (is_rd && hit),
                .wr_i    (is_wr && hit),
                .auto_precharge_flag_i (link.addr[dbr_pkg::AUTO_PRECHARGE_FLAG_BIT]),
                .ref_i   (is_ref && s_q.rfc == '0),
                .row_i   (link.addr[dbr_pkg::ROW_W-1:0]),
                .state_o (bank_st[g]),
                .row_o   (),
                .bad_o   (bank_bad[g])
            );
        end
    endgenerate

    // ************************************************************
    // refresh counter, lockout, skipping, error flag
    // ************************************************************
    always_comb
    begin
        s_d     = s_q;
        s_d.err = 1'b0;
        if (s_q.rfc != '0)
        begin
            s_d.rfc = s_q.rfc - 1'b1;
            if (!link.cs_n)
                s_d.err = 1'b1;
        end
        else if (is_ref)
        begin
            s_d.rfc = rfc_len;
            // every refresh is registered; some skip internal row step
            if (TEMP_REFRESH_EN_I && TEMP_BELOW_45_I)
            begin
                s_d.skip = s_q.skip + 1'b1;
                if (s_q.skip == 2'(dbr_pkg::SKIP_RATIO - 1))
                begin
                    s_d.skip = '0;
                    s_d.rcnt = s_q.rcnt + 1'b1;
                end
            end
            else
                s_d.rcnt = s_q.rcnt + 1'b1;
        end
        if (|bank_bad)
            s_d.err = 1'b1;
        s_d.err_o = s_q.err;
        s_d.busy  = (s_d.rfc != '0);
        for (int i = 0; i < dbr_pkg::NBANK; i++)
            s_d.open[i] = (bank_st[i] == dbr_pkg::BK_ACTIVE);
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            s_q <= '0;
        else if (CE_I)
            s_q <= s_d;
    end

    assign link.err    = s_q.err;
    assign BANK_OPEN_O = s_q.open;
    assign REF_ROW_O   = s_q.rcnt;
    assign REF_BUSY_O  = s_q.busy;
    assign CMD_ERR_O   = s_q.err_o;
endmodule

// ===== dbr_pkg.sv
// package of shared constants and types for the bank and refresh command model
// assumes a 125 MHz system clock and a single command slot per cycle
package dbr_pkg;

    // ************************************************************
    // geometry
    // ************************************************************
    localparam int unsigned BG_W      = 2;
    localparam int unsigned BA_W      = 2;
    localparam int unsigned ROW_W     = 18;
    localparam int unsigned NBANK     = 16;
    localparam int unsigned BANK_W    = 4;
    localparam int unsigned ADDR_W    = 18;
    localparam int unsigned AUTO_PRECHARGE_FLAG_BIT = 10;
    localparam int unsigned FGR_W     = 3;
    localparam int unsigned RCNT_W    = 16;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_PS    = 8000;
    localparam int unsigned TRP_PS    = 15000;
    localparam int unsigned TRRDS_PS  = 5300;
    localparam int unsigned TRRDL_PS  = 6400;
    localparam int unsigned TFAW_PS   = 30000;
    localparam int unsigned TWR_PS    = 15000;
    localparam int unsigned TRTP_PS   = 7500;
    localparam int unsigned TRFC1_NS  = 260;
    localparam int unsigned TRFC2_NS  = 160;
    localparam int unsigned TRFC4_NS  = 110;
    localparam int unsigned TREFI_NS  = 7800;
    localparam int unsigned BURST_CYC = 4;

    localparam int unsigned TRP_CYC   = (TRP_PS + CLK_PS - 1) / CLK_PS;
    localparam int unsigned TRRDS_CYC = (TRRDS_PS + CLK_PS - 1) / CLK_PS;
    localparam int unsigned TRRDL_CYC = (TRRDL_PS + CLK_PS - 1) / CLK_PS;
    localparam int unsigned TFAW_CYC  = (TFAW_PS + CLK_PS - 1) / CLK_PS;
    localparam int unsigned TWR_CYC   = (TWR_PS + CLK_PS - 1) / CLK_PS;
    localparam int unsigned TRTP_CYC  = (TRTP_PS + CLK_PS - 1) / CLK_PS;
    localparam int unsigned TRFC1_CYC = (TRFC1_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned TRFC2_CYC = (TRFC2_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned TRFC4_CYC = (TRFC4_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned TREFI_CYC = (TREFI_NS * 1000) / CLK_PS;

    localparam int unsigned TMR_W     = 8;
    localparam int unsigned RFC_W     = 6;

    // ************************************************************
    // refresh limits
    // ************************************************************
    localparam int unsigned POST_MAX1 = 8;
    localparam int unsigned POST_MAX2 = 16;
    localparam int unsigned POST_MAX4 = 32;
    localparam int unsigned CRED_W    = 7;
    localparam int unsigned SKIP_RATIO = 2;

    // fine granularity refresh field codes
    localparam logic [2:0] FGR_FIX1 = 3'h0;
    localparam logic [2:0] FGR_FIX2 = 3'h1;
    localparam logic [2:0] FGR_FIX4 = 3'h2;
    localparam logic [2:0] FGR_OTF2 = 3'h5;
    localparam logic [2:0] FGR_OTF4 = 3'h6;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        CMD_DES,
        CMD_ACT,
        CMD_PRE,
        CMD_PREA,
        CMD_RD,
        CMD_WR,
        CMD_REF,
        CMD_NOP
    } dbr_cmd_t;

    typedef enum logic [1:0] {
        BK_IDLE,
        BK_ACTIVE,
        BK_PRECH
    } dbr_bank_t;

endpackage

// ===== dbr_if.sv
// interface carrying the command and address pins between controller and device
// assumes both ends run on the same system clock
interface dbr_if;
    logic                        cs_n;
    logic                        act_n;
    logic                        ras_n;
    logic                        cas_n;
    logic                        we_n;
    logic [dbr_pkg::BG_W-1:0]    bg;
    logic [dbr_pkg::BA_W-1:0]    ba;
    logic [dbr_pkg::ADDR_W-1:0]  addr;
    logic                        err;

    // ************************************************************
    // modports
    // ************************************************************
    modport ctrl (output cs_n, output act_n, output ras_n, output cas_n, output we_n,
                  output bg, output ba, output addr, input err);
    modport dev  (input cs_n, input act_n, input ras_n, input cas_n, input we_n,
                  input bg, input ba, input addr, output err);
endinterface

// ===== dbr_bank.sv
// one bank state machine: idle, active with open row, precharging
// assumes the caller presents at most one decoded command per cycle
module dbr_bank (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       en_i,
    input  wire logic                       act_i,
    input  wire logic                       pre_i,
    input  wire logic                       rd_i,
    input  wire logic                       wr_i,
    input  wire logic                       auto_precharge_flag_i,
    input  wire logic                       ref_i,
    input  wire logic [dbr_pkg::ROW_W-1:0]  row_i,
    output dbr_pkg::dbr_bank_t              state_o,
    output logic      [dbr_pkg::ROW_W-1:0]  row_o,
    output logic                            bad_o
);
    typedef struct packed {
        dbr_pkg::dbr_bank_t               st;
        logic [dbr_pkg::ROW_W-1:0]        row;
        logic [dbr_pkg::TMR_W-1:0]        tmr;
        logic                             auto_pend;
        logic [dbr_pkg::TMR_W-1:0]        auto_tmr;
        logic                             bad;
    } dbr_bank_st_t;

    dbr_bank_st_t s_q, s_d;
    logic         rdy;

    // precharge period over counts as idle again
    assign rdy = (s_q.st == dbr_pkg::BK_IDLE)
                 || (s_q.st == dbr_pkg::BK_PRECH && s_q.tmr == '0);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        s_d     = s_q;
        s_d.bad = 1'b0;
        if (s_q.tmr != '0)
            s_d.tmr = s_q.tmr - 1'b1;
        if (s_q.st == dbr_pkg::BK_PRECH && s_q.tmr == '0)
            s_d.st = dbr_pkg::BK_IDLE;
        // auto precharge waits for restore or write data store
        if (s_q.auto_pend)
        begin
            if (s_q.auto_tmr != '0)
                s_d.auto_tmr = s_q.auto_tmr - 1'b1;
            else
            begin
                s_d.auto_pend = 1'b0;
                s_d.st        = dbr_pkg::BK_PRECH;
                s_d.tmr       = dbr_pkg::TMR_W'(dbr_pkg::TRP_CYC - 1);
            end
        end
        if (act_i)
        begin
            if (rdy)
            begin
                s_d.st  = dbr_pkg::BK_ACTIVE;
                s_d.row = row_i;
            end
            else
                s_d.bad = 1'b1;
        end
        else if (pre_i)
        begin
            // precharge to idle or precharging bank restarts the period
            s_d.st      = dbr_pkg::BK_PRECH;
            s_d.tmr     = dbr_pkg::TMR_W'(dbr_pkg::TRP_CYC - 1);
            s_d.auto_pend = 1'b0;
        end
        else if (rd_i || wr_i)
        begin
            if (s_q.st != dbr_pkg::BK_ACTIVE || s_q.auto_pend)
                s_d.bad = 1'b1;
            else if (auto_precharge_flag_i)
            begin
                s_d.auto_pend = 1'b1;
                // write waits for last data plus recovery
                s_d.auto_tmr  = wr_i ? dbr_pkg::TMR_W'(dbr_pkg::BURST_CYC + dbr_pkg::TWR_CYC)
                                     : dbr_pkg::TMR_W'(dbr_pkg::TRTP_CYC);
            end
        end
        else if (ref_i)
        begin
            if (!rdy)
                s_d.bad = 1'b1;
            s_d.st = dbr_pkg::BK_IDLE;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s_q <= '{st: dbr_pkg::BK_IDLE, default: '0};
        else if (en_i)
            s_q <= s_d;
    end

    assign state_o = s_q.st;
    assign row_o   = s_q.row;
    assign bad_o   = s_q.bad;
endmodule

// ===== dbr_ctrl.sv
// controller end: issues commands with activate spacing and refresh scheduling
// assumes one user request at a time, held until accepted
module dbr_ctrl (
    input  wire logic                          CLK_SYS_I,
    input  wire logic                          RST_I,
    input  wire logic                          CE_I,
    dbr_if.ctrl                                link,
    input  wire logic                          REQ_I,
    input  wire dbr_pkg::dbr_cmd_t             REQ_CMD_I,
    input  wire logic [dbr_pkg::BANK_W-1:0]    REQ_BANK_I,
    input  wire logic [dbr_pkg::ADDR_W-1:0]    REQ_ADDR_I,
    input  wire logic                          HOT_I,
    output logic                               ACK_O,
    output logic signed [dbr_pkg::CRED_W-1:0]  REF_CREDIT_O
);
    typedef struct packed {
        logic [4:0]                          cmd;
        logic [dbr_pkg::BG_W-1:0]            bg;
        logic [dbr_pkg::BA_W-1:0]            ba;
        logic [dbr_pkg::ADDR_W-1:0]          addr;
        logic                                ack;
        logic [dbr_pkg::TMR_W-1:0]           rrd;
        logic [dbr_pkg::BG_W-1:0]            last_bg;
        logic [3:0][dbr_pkg::TMR_W-1:0]      faw;
        logic [dbr_pkg::TMR_W-1:0]           blk;
        logic [10:0]                         refi;
        logic signed [dbr_pkg::CRED_W-1:0]   cred;
    } dbr_ctrl_st_t;

    dbr_ctrl_st_t s_q, s_d;
    logic faw_ok, rrd_ok, go;
    // signed unit step, so the credit sign is never flipped by extension
    localparam logic signed [dbr_pkg::CRED_W-1:0] CRED_STEP = dbr_pkg::CRED_W'(1);

    // ************************************************************
    // activate spacing checks
    // ************************************************************
    assign rrd_ok = (s_q.rrd == '0);
    assign faw_ok = (s_q.faw[3] == '0);

    always_comb
    begin
        s_d     = s_q;
        s_d.cmd = 5'h1F; // deselect
        s_d.ack = 1'b0;
        go      = 1'b0;
        if (s_q.blk != '0)
            s_d.blk = s_q.blk - 1'b1;
        if (s_q.rrd != '0)
            s_d.rrd = s_q.rrd - 1'b1;
        for (int i = 0; i < 4; i++)
            if (s_q.faw[i] != '0)
                s_d.faw[i] = s_q.faw[i] - 1'b1;
        // interval tick adds owed refresh, halved under heat
        if (s_q.refi == '0)
        begin
            s_d.refi = HOT_I ? 11'(dbr_pkg::TREFI_CYC / 2 - 1)
                             : 11'(dbr_pkg::TREFI_CYC - 1);
            s_d.cred = s_q.cred - CRED_STEP;
        end
        else
            s_d.refi = s_q.refi - 1'b1;
        if (s_q.blk == '0)
        begin
            // forced refresh once postpone limit reached
            if (s_q.cred <= -$signed(dbr_pkg::CRED_W'(dbr_pkg::POST_MAX1))
                || (REQ_I && REQ_CMD_I == dbr_pkg::CMD_REF))
            begin
                s_d.cmd  = 5'b0_1001;
                s_d.blk  = dbr_pkg::TMR_W'(dbr_pkg::TRFC1_CYC);
                if (s_q.cred < $signed(dbr_pkg::CRED_W'(dbr_pkg::POST_MAX1)))
                    s_d.cred = s_d.cred + CRED_STEP;
                s_d.ack  = REQ_I && REQ_CMD_I == dbr_pkg::CMD_REF;
            end
            else if (REQ_I)
            begin
                unique case (REQ_CMD_I)
                    dbr_pkg::CMD_ACT:
                    begin
                        go = faw_ok && (rrd_ok ||
                             (s_q.last_bg != REQ_BANK_I[3:2] && s_q.rrd <=
                              dbr_pkg::TMR_W'(dbr_pkg::TRRDL_CYC - dbr_pkg::TRRDS_CYC)));
                        if (go)
                        begin
                            s_d.cmd     = 5'h00;
                            s_d.rrd     = dbr_pkg::TMR_W'(dbr_pkg::TRRDL_CYC - 1);
                            s_d.last_bg = REQ_BANK_I[3:2];
                            s_d.faw     = {s_d.faw[2:0],
                                           dbr_pkg::TMR_W'(dbr_pkg::TFAW_CYC - 1)};
                        end
                    end
                    dbr_pkg::CMD_PRE:  begin go = 1'b1; s_d.cmd = 5'b0_1010; end
                    dbr_pkg::CMD_PREA: begin go = 1'b1; s_d.cmd = 5'b0_1010; end
                    dbr_pkg::CMD_RD:   begin go = 1'b1; s_d.cmd = 5'b0_1101; end
                    dbr_pkg::CMD_WR:   begin go = 1'b1; s_d.cmd = 5'b0_1100; end
                    default:           begin go = 1'b1; end
                endcase
                s_d.ack = go;
            end
            if (s_d.ack || s_d.cmd != 5'h1F)
            begin
                s_d.bg   = REQ_BANK_I[3:2];
                s_d.ba   = REQ_BANK_I[1:0];
                s_d.addr = REQ_ADDR_I;
                if (REQ_CMD_I == dbr_pkg::CMD_PREA)
                    s_d.addr[dbr_pkg::AUTO_PRECHARGE_FLAG_BIT] = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            s_q <= '{cmd: 5'h1F, refi: 11'h7FF, default: '0};
        else if (CE_I)
            s_q <= s_d;
    end

    // ************************************************************
    // pins: cmd = {cs_n, act_n, ras_n, cas_n, we_n}
    // ************************************************************
    assign link.cs_n   = s_q.cmd[4];
    assign link.act_n  = s_q.cmd[3];
    assign link.ras_n  = s_q.cmd[2];
    assign link.cas_n  = s_q.cmd[1];
    assign link.we_n   = s_q.cmd[0];
    assign link.bg     = s_q.bg;
    assign link.ba     = s_q.ba;
    assign link.addr   = s_q.addr;
    assign ACK_O       = s_q.ack;
    assign REF_CREDIT_O = s_q.cred;
endmodule

// ===== dbr_checker.sv
// checker on the command pins between the controller and device ends
// assumes it sits beside the one interface that joins the two ends
module dbr_checker (
    input wire logic        CLK_SYS_I,
    input wire logic        RST_I,
    input wire logic        cs_n,
    input wire logic        act_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [1:0]  bg,
    input wire logic [1:0]  ba,
    input wire logic [17:0] addr,
    input wire logic        err
);
    localparam int LOCK = dbr_pkg::TRFC1_CYC - 1;
    logic [15:0] open_q;
    logic [5:0]  lock_q;
    wire         act = !cs_n && !act_n;
    wire         pre = !cs_n && act_n && !ras_n && cas_n && !we_n;
    wire         acc = !cs_n && act_n && ras_n && !cas_n;
    wire         ref_c = !cs_n && act_n && !ras_n && !cas_n && we_n;
    wire [3:0]   bk = {bg, ba};

    // open rows per bank and refresh lockout count
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
        begin
            open_q <= 16'h0000;
            lock_q <= 6'h00;
        end
        else
        begin
            if (act)
                open_q[bk] <= 1'b1;
            if (pre && addr[10])
                open_q <= 16'h0000;
            else if (pre || (acc && addr[10]))
                open_q[bk] <= 1'b0;
            lock_q <= ref_c ? 6'(LOCK) : lock_q - 6'(lock_q != 6'h00);
        end
    end

    // refresh command and the quiet pins after it
    sequence s_ref;
        ref_c;
    endsequence
    sequence s_quiet;
        cs_n [*8];
    endsequence
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (RST_I);

    cmd_gap_a: assert property (!cs_n |=> cs_n)
        else $error("command held past one cycle");
    ref_lock_a: assert property (lock_q != 6'h00 |-> cs_n)
        else $error("command inside refresh lockout");
    ref_quiet_a: assert property (s_ref |=> s_quiet)
        else $error("refresh not followed by deselects");
    ref_idle_a: assert property (s_ref |-> open_q == 16'h0000)
        else $error("refresh with a bank open");
    act_shut_a: assert property (act |-> !open_q[bk])
        else $error("activate to an open bank");
    acc_open_a: assert property (acc |-> open_q[bk])
        else $error("access to an idle bank");
    err_cause_a: assert property (err |-> !$past(cs_n) || !$past(cs_n, 2))
        else $error("error flag without a command");
    rst_idle_a: assert property ($past(RST_I) |-> cs_n)
        else $error("command at reset release");
endmodule

// ===== ddr4_bank_refresh_command_rules_tb.sv
// bench joining controller and device ends through the pin interface
// assumes package, interface, both ends and checker compile first
module ddr4_bank_refresh_command_rules_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 40000;
    logic              clk_sys = 1'b0;
    logic              rst = 1'b1;
    logic              req = 1'b0;
    logic              hot = 1'b0;
    logic              temp_ref_en = 1'b0;
    logic              cool = 1'b0;
    logic [2:0]        fgr = 3'h0;
    dbr_pkg::dbr_cmd_t cmd = dbr_pkg::CMD_DES;
    logic [3:0]        bank = 4'h0;
    logic [17:0]       addr = 18'h00000;
    logic [15:0]       bank_open;
    logic [15:0]       ref_row;
    logic              ack;
    logic              busy;
    logic              cmd_err;
    logic signed [6:0] credit;
    int                fails = 0;
    int                samples_checked = 0;
    int                cyc = 0;
    int                errs = 0;

    dbr_if dbr_if_inst ();
    dbr_ctrl dbr_ctrl_inst (.CLK_SYS_I(clk_sys), .RST_I(rst), .CE_I(1'b1), .link(dbr_if_inst),
        .REQ_I(req), .REQ_CMD_I(cmd), .REQ_BANK_I(bank), .REQ_ADDR_I(addr), .HOT_I(hot),
        .ACK_O(ack), .REF_CREDIT_O(credit));
    dbr_dev dbr_dev_inst (.CLK_SYS_I(clk_sys), .RST_I(rst), .CE_I(1'b1), .link(dbr_if_inst),
        .FGR_MODE_I(fgr), .TEMP_REFRESH_EN_I(temp_ref_en), .TEMP_BELOW_45_I(cool),
        .BANK_OPEN_O(bank_open), .REF_ROW_O(ref_row), .REF_BUSY_O(busy), .CMD_ERR_O(cmd_err));
    dbr_checker dbr_checker_inst (.CLK_SYS_I(clk_sys), .RST_I(rst), .cs_n(dbr_if_inst.cs_n),
        .act_n(dbr_if_inst.act_n), .ras_n(dbr_if_inst.ras_n), .cas_n(dbr_if_inst.cas_n),
        .we_n(dbr_if_inst.we_n), .bg(dbr_if_inst.bg), .ba(dbr_if_inst.ba),
        .addr(dbr_if_inst.addr), .err(dbr_if_inst.err));

    // clock, cycle ceiling and error pulse count
    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cyc++;
        fails += int'(cyc == LIMIT);
        if (cyc == LIMIT)
            print_verdict();
    end
    always @(negedge clk_sys) errs += int'(cmd_err === 1'b1);

    // comparison, waiting and request tasks
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic issue(input dbr_pkg::dbr_cmd_t c, input logic [3:0] b, input logic [17:0] a);
        int n;
        n = 0;
        tick(1);
        cmd = c;
        bank = b;
        addr = a;
        req = 1'b1;
        while (ack !== 1'b1 && n < 300)
        begin
            tick(1);
            n++;
        end
        req = 1'b0;
        fails += int'(n == 300);
    endtask
    function automatic int rfc(input int m);
        return m == 0 ? dbr_pkg::TRFC1_CYC : m == 1 ? dbr_pkg::TRFC2_CYC : dbr_pkg::TRFC4_CYC;
    endfunction
    function automatic int rows(input int n);
        return (temp_ref_en && cool) ? n / dbr_pkg::SKIP_RATIO : n;
    endfunction
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // main sequence
    initial
    begin
        int r0, len, base;
        logic [15:0] mask;
        void'($urandom(32'hF99856AC));
        tick(20);
        rst = 1'b0;
        r0 = ref_row;
        for (int i = 0; i < 10; i++)
        begin
            fgr = i < 3 ? 3'(i) : (i == 3 ? dbr_pkg::FGR_OTF4 : 3'h0);
            issue(dbr_pkg::CMD_REF, i == 3 ? 4'h4 : 4'($urandom), 18'($urandom));
            len = 0;
            repeat (60)
            begin
                len += int'(busy === 1'b1);
                tick(1);
            end
            if (i < 4)
                check(18'(len), 18'(rfc(i == 3 ? 2 : i)));
        end
        check(18'(ref_row - r0), 18'(rows(10)));
        check(18'(credit), 18'h00008);
        $display("test 1 done");
        for (int k = 0; k < 3; k++)
        begin
            base = $urandom;
            mask = 16'h0000;
            for (int i = 0; i < 5; i++)
            begin
                issue(dbr_pkg::CMD_ACT, 4'(base + i * 5), 18'($urandom));
                mask[4'(base + i * 5)] = 1'b1;
            end
            tick(3);
            check(18'(bank_open), 18'(mask));
            issue(dbr_pkg::CMD_RD, 4'(base), 18'h00400);
            issue(dbr_pkg::CMD_WR, 4'(base + 5), 18'h00400);
            tick(20);
            check(18'(bank_open[4'(base)]), 18'h00000);
            check(18'(bank_open[4'(base + 5)]), 18'h00000);
            issue(dbr_pkg::CMD_PRE, 4'(base), 18'h00000);
            issue(dbr_pkg::CMD_PRE, 4'h0, 18'h00400);
            tick(3);
            check(18'(bank_open), 18'h00000);
        end
        check(18'(errs), 18'h00000);
        $display("test 2 done");
        temp_ref_en = 1'b1;
        cool = 1'b1;
        r0 = ref_row;
        repeat (4) issue(dbr_pkg::CMD_REF, 4'h0, 18'($urandom));
        tick(40);
        check(18'(ref_row - r0), 18'(rows(4)));
        temp_ref_en = 1'b0;
        $display("test 3 done");
        r0 = ref_row;
        tick(20 * dbr_pkg::TREFI_CYC);
        check(18'(credit >= -8), 18'h00001);
        check(18'(ref_row != 16'(r0)), 18'h00001);
        hot = 1'b1;
        temp_ref_en = 1'b1;
        cool = 1'b0;
        r0 = ref_row;
        tick(10 * dbr_pkg::TREFI_CYC);
        check(18'(credit >= -8), 18'h00001);
        check(18'(16'(ref_row - r0) >= 16'h0012), 18'h00001);
        $display("test 4 done");
        print_verdict();
    end
endmodule
